// File: src/fmrds_core.sv
// FM audio post-processing (blend, mute, high cut, pause) and data decoder.
// Assumes audio samples, C/N and syndrome-checked blocks arrive from the
// demodulator on this clock, one-cycle valid strobes.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
module fmrds_core #(
  parameter int DEPTH = 126,
  parameter int AW    = 16
) (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst,
  input  wire logic [5:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [31:0]                  o_rdata,
  input  wire logic [7:0]              i_cn,
  input  wire logic                    i_aud_vld,
  input  wire logic signed [AW-1:0]    i_aud_l,
  input  wire logic signed [AW-1:0]    i_aud_r,
  input  wire logic                    i_blk_vld,
  input  wire logic [15:0]             i_blk_data,
  input  wire fmrds_pkg::fmrds_blk_t   i_blk_type,
  input  wire logic [1:0]              i_blk_errs,
  input  wire logic                    i_blk_fixable,
  output logic signed [AW-1:0]         o_aud_l,
  output logic signed [AW-1:0]         o_aud_r,
  output logic                         o_aud_vld,
  output logic [7:0]                   o_hcut,
  output logic                         o_irq
);
  import fmrds_pkg::*;

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  wire wr_ctrl  = i_wr && (i_addr == REG_CTRL);
  wire wr_istat = i_wr && (i_addr == REG_IRQ_STAT);
  wire wr_imask = i_wr && (i_addr == REG_IRQ_MASK);
  wire wr_thr   = i_wr && (i_addr == REG_THR_SW);
  wire wr_pause = i_wr && (i_addr == REG_PAUSE);
  wire wr_sync  = i_wr && (i_addr == REG_SYNC);
  wire wr_bpat  = i_wr && (i_addr == REG_BPAT);
  wire wr_pi    = i_wr && (i_addr == REG_PI);
  wire rd_fifo  = i_rd && (i_addr == REG_FIFO);
  wire wr_sep   = i_wr && (i_addr[5:3] == REG_SEP_TAB[5:3]);
  wire wr_mute  = i_wr && (i_addr[5:3] == REG_MUTE_TAB[5:3]);
  wire wr_hcut  = i_wr && (i_addr[5:3] == REG_HCUT_TAB[5:3]);

  // Control: bit0 switch mode, bit1 block E filter, bit2 flush buffer
  logic        mode_sw_q, efilt_q;
  logic [7:0]  s2m_q, m2s_q;
  logic [15:0] pthr_q, pdur_q;
  logic [3:0]  pfilt_q, acq_q, loss_q;
  logic [15:0] bpat_q, bmask_q, pi_q;
  logic [IRQ_W-1:0] imask_q;

  // Host configuration registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_sw_q <= 1'b0;
      efilt_q   <= 1'b0;
      s2m_q     <= RST_S2M;
      m2s_q     <= RST_M2S;
      pthr_q    <= RST_PTHR;
      pdur_q    <= RST_PDUR;
      pfilt_q   <= RST_PFILT;
      acq_q     <= RST_ACQ;
      loss_q    <= RST_LOSS;
      bpat_q    <= 16'h0000;
      bmask_q   <= 16'h0000;
      pi_q      <= 16'h0000;
      imask_q   <= '0;
    end else begin
      if (wr_ctrl) begin
        mode_sw_q <= i_wdata[0];
        efilt_q   <= i_wdata[1];
      end
      if (wr_thr) begin
        s2m_q <= i_wdata[7:0];
        m2s_q <= i_wdata[15:8];
      end
      if (wr_pause) begin
        pthr_q  <= i_wdata[15:0];
        pdur_q  <= i_wdata[31:16];
      end
      if (wr_sync) begin
        // Acquire count floors at two good blocks
        acq_q   <= (i_wdata[3:0] < MIN_ACQ) ? MIN_ACQ : i_wdata[3:0];
        loss_q  <= i_wdata[7:4];
        pfilt_q <= i_wdata[11:8];
      end
      if (wr_bpat) begin
        bpat_q  <= i_wdata[15:0];
        bmask_q <= i_wdata[31:16];
      end
      if (wr_pi) pi_q <= i_wdata[15:0];
      if (wr_imask) imask_q <= i_wdata[IRQ_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // C/N characteristic tables, 8 breakpoints each
  // ------------------------------------------------------------------
  logic [7:0] sep_tab_q  [8];
  logic [7:0] mute_tab_q [8];
  logic [7:0] hcut_tab_q [8];
  wire  [2:0] cn_idx = i_cn[7:5];

  // One table entry per word; the top three C/N bits select the entry
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_tab
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          sep_tab_q[g]  <= 8'hff;
          mute_tab_q[g] <= 8'hff;
          hcut_tab_q[g] <= 8'h00;
        end else begin
          if (wr_sep && i_addr[2:0] == 3'(g)) sep_tab_q[g] <= i_wdata[7:0];
          if (wr_mute && i_addr[2:0] == 3'(g)) mute_tab_q[g] <= i_wdata[7:0];
          if (wr_hcut && i_addr[2:0] == 3'(g)) hcut_tab_q[g] <= i_wdata[7:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Stereo blend / switch, soft mute, high cut
  // ------------------------------------------------------------------
  logic stereo_q;
  // Hysteresis: leave stereo below s2m, return at or above m2s
  always_ff @(posedge i_clock) begin
    if (i_rst) stereo_q <= 1'b0;
    else if (stereo_q && i_cn < s2m_q) stereo_q <= 1'b0;
    else if (!stereo_q && i_cn >= m2s_q) stereo_q <= 1'b1;
  end

  // Separation in 1/256 units; switch mode is all or nothing
  wire [8:0] sep = mode_sw_q ? (stereo_q ? 9'h100 : 9'h000)
                             : {1'b0, sep_tab_q[cn_idx]} + 9'(sep_tab_q[cn_idx][7]);
  wire [8:0] gain = {1'b0, mute_tab_q[cn_idx]} + 9'(mute_tab_q[cn_idx][7]);

  // Mid/side rebuild: L = M + sep*S, R = M - sep*S
  wire signed [AW:0]    mid   = (AW+1)'((i_aud_l + i_aud_r) >>> 1);
  wire signed [AW:0]    side  = (AW+1)'((i_aud_l - i_aud_r) >>> 1);
  wire signed [AW+10:0] s_sc  = (AW+11)'((side * $signed({1'b0, sep})) >>> 8);
  wire signed [AW+10:0] l_pre = (AW+11)'(mid) + s_sc;
  wire signed [AW+10:0] r_pre = (AW+11)'(mid) - s_sc;
  wire signed [AW+20:0] l_mu  = (AW+21)'((l_pre * $signed({1'b0, gain})) >>> 8);
  wire signed [AW+20:0] r_mu  = (AW+21)'((r_pre * $signed({1'b0, gain})) >>> 8);

  // Output registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_aud_l   <= '0;
      o_aud_r   <= '0;
      o_aud_vld <= 1'b0;
      o_hcut    <= 8'h00;
    end else begin
      o_aud_vld <= i_aud_vld;
      o_hcut    <= hcut_tab_q[cn_idx];
      if (i_aud_vld) begin
        o_aud_l <= AW'(l_mu);
        o_aud_r <= AW'(r_mu);
      end
    end
  end

  // ------------------------------------------------------------------
  // Audio pause detection
  // ------------------------------------------------------------------
  wire [AW-1:0] mag_l = i_aud_l[AW-1] ? AW'(-i_aud_l) : AW'(i_aud_l);
  wire [AW-1:0] mag_r = i_aud_r[AW-1] ? AW'(-i_aud_r) : AW'(i_aud_r);
  wire          quiet = (mag_l < AW'(pthr_q)) && (mag_r < AW'(pthr_q));

  logic [3:0]  flt_q;
  logic        silent_q;
  logic [15:0] pcnt_q;
  logic        paused_q;
  // Debounce the quiet decision both ways over pfilt samples
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flt_q    <= 4'h0;
      silent_q <= 1'b0;
    end else if (i_aud_vld) begin
      if (quiet == silent_q) flt_q <= 4'h0;
      else if (flt_q >= pfilt_q) begin
        silent_q <= quiet;
        flt_q    <= 4'h0;
      end else flt_q <= flt_q + 4'h1;
    end
  end

  // Silence must last pdur samples before the event
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pcnt_q   <= 16'h0000;
      paused_q <= 1'b0;
    end else if (!silent_q) begin
      pcnt_q   <= 16'h0000;
      paused_q <= 1'b0;
    end else if (i_aud_vld && !paused_q) begin
      if (pcnt_q >= pdur_q) paused_q <= 1'b1;
      else pcnt_q <= pcnt_q + 16'h0001;
    end
  end
  wire ev_pause = silent_q && i_aud_vld && !paused_q && (pcnt_q >= pdur_q);

  // ------------------------------------------------------------------
  // Flywheel sync on block quality
  // ------------------------------------------------------------------
  fmrds_sync_t sst_q;
  logic [3:0]  good_q, bad_q;
  wire  blk_ok  = i_blk_vld && (i_blk_errs == 2'b00);
  wire  blk_use = i_blk_vld && (i_blk_errs == 2'b00 || i_blk_fixable);
  wire  locked  = (sst_q == FMRDS_LOCK);

  // Acquire on acq good in a row, drop after loss bad in a row
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sst_q  <= FMRDS_SEARCH;
      good_q <= 4'h0;
      bad_q  <= 4'h0;
    end else if (i_blk_vld) begin
      unique case (sst_q)
        FMRDS_SEARCH, FMRDS_ACQ: begin
          if (!blk_ok) begin
            sst_q  <= FMRDS_SEARCH;
            good_q <= 4'h0;
          end else if (good_q + 4'h1 >= acq_q) begin
            sst_q  <= FMRDS_LOCK;
            bad_q  <= 4'h0;
          end else begin
            sst_q  <= FMRDS_ACQ;
            good_q <= good_q + 4'h1;
          end
        end
        FMRDS_LOCK: begin
          if (blk_use) bad_q <= 4'h0;
          else if (bad_q + 4'h1 >= loss_q) begin
            sst_q  <= FMRDS_SEARCH;
            good_q <= 4'h0;
          end else bad_q <= bad_q + 4'h1;
        end
        default: sst_q <= FMRDS_SEARCH;
      endcase
    end
  end
  wire ev_sync = i_blk_vld && !locked && blk_ok && (good_q + 4'h1 >= acq_q);

  // ------------------------------------------------------------------
  // Block buffer
  // ------------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [18:0]   mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0]   cnt_q;
  logic          ovf_q;
  wire  efilt_hit = efilt_q && (i_blk_type == FMRDS_BLK_E);
  wire  store     = (locked || ev_sync) && blk_use && !efilt_hit;
  wire  full      = (cnt_q == (PW+1)'(DEPTH));
  wire  empty     = (cnt_q == '0);
  wire  push      = store && !full;
  wire  pop       = rd_fifo && !empty;
  wire  ev_ovf    = store && full;
  wire  flush     = wr_ctrl && i_wdata[2];

  // Write and read pointers wrap at DEPTH
  always_ff @(posedge i_clock) begin
    if (i_rst || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (pop)  rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge i_clock) begin
    if (push) mem_q[wp_q] <= {i_blk_type, i_blk_data};
  end

  // Overflow flag holds until the buffer has been drained
  always_ff @(posedge i_clock) begin
    if (i_rst || flush) ovf_q <= 1'b0;
    else if (ev_ovf) ovf_q <= 1'b1;
    else if (empty) ovf_q <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Block B and PI matching
  // ------------------------------------------------------------------
  wire ev_bmat = push && (i_blk_type == FMRDS_BLK_B)
              && (((i_blk_data ^ bpat_q) & bmask_q) == 16'h0000);
  wire ev_pi   = push && (i_blk_type == FMRDS_BLK_A || i_blk_type == FMRDS_BLK_CP)
              && (i_blk_data == pi_q);

  // ------------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set beats clear
  // ------------------------------------------------------------------
  logic [IRQ_W-1:0] istat_q;
  wire  [IRQ_W-1:0] ev_set = {ev_sync, ev_ovf, ev_pi, ev_bmat, ev_pause};
  wire  [IRQ_W-1:0] ev_clr = wr_istat ? i_wdata[IRQ_W-1:0] : '0;
  always_ff @(posedge i_clock) begin
    if (i_rst) istat_q <= '0;
    else istat_q <= (istat_q & ~ev_clr) | ev_set;
  end
  assign o_irq = |(istat_q & imask_q);

  // ------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------------
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (i_addr)
      REG_CTRL:     rmux = {30'h0, efilt_q, mode_sw_q};
      REG_STATUS:   rmux = {24'h0, ovf_q, full, empty, silent_q, locked, stereo_q, sst_q};
      REG_IRQ_STAT: rmux = 32'(istat_q);
      REG_IRQ_MASK: rmux = 32'(imask_q);
      REG_THR_SW:   rmux = {16'h0, m2s_q, s2m_q};
      REG_PAUSE:    rmux = {pdur_q, pthr_q};
      REG_SYNC:     rmux = {20'h0, pfilt_q, loss_q, acq_q};
      REG_BPAT:     rmux = {bmask_q, bpat_q};
      REG_PI:       rmux = {16'h0, pi_q};
      REG_FIFO:     rmux = empty ? 32'h0 : {12'h0, 1'b1, mem_q[rp_q]};
      REG_LEVEL:    rmux = 32'(cnt_q);
      default: begin
        if (i_addr[5:3] == REG_SEP_TAB[5:3])       rmux = {24'h0, sep_tab_q[i_addr[2:0]]};
        else if (i_addr[5:3] == REG_MUTE_TAB[5:3]) rmux = {24'h0, mute_tab_q[i_addr[2:0]]};
        else if (i_addr[5:3] == REG_HCUT_TAB[5:3]) rmux = {24'h0, hcut_tab_q[i_addr[2:0]]};
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) o_rdata <= 32'h0;
    else o_rdata <= i_rd ? rmux : 32'h0;
  end

endmodule : fmrds_core

// File: src/fmrds_pkg.sv
// Constants for the FM audio post-processing and data decoder block.
// Assumes one 10 MHz clock and a plain register port from the host side.
// Operation
// - Stereo or mono chosen automatically from C/N, blend or switch mode.
// - Blend mode: separation follows a host-programmed C/N table.
// - Switch mode: output jumps between full stereo and full mono.
// - Separate stereo-to-mono and mono-to-stereo thresholds give hysteresis.
// - Soft mute attenuates audio by a programmable function of C/N.
// - High-cut amount is a programmable function of C/N.
// - Interrupt when audio magnitude stays under threshold for programmed time.
// - Pause detection filtered both ways against brief fluctuations.
// - Decoder takes checked blocks, accepts fixable ones, keeps block sync.
// - Flywheel sync with programmable acquire and loss parameters.
// - Sync after programmable count of good blocks in a row, minimum two.
// - Received blocks buffered for the host, up to 126.
// - Block B compared to masked host pattern, interrupt on match.
// - Program identification matching host value raises an interrupt.
// - Host reads buffered blocks over the command interface.
// - All configuration is written by the host.
package fmrds_pkg;

  // ------------------------------------------------------------------
  // Register map, word offsets on the host port
  // ------------------------------------------------------------------
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_STATUS   = 6'h01;
  localparam logic [5:0] REG_IRQ_STAT = 6'h02;
  localparam logic [5:0] REG_IRQ_MASK = 6'h03;
  localparam logic [5:0] REG_THR_SW   = 6'h04;
  localparam logic [5:0] REG_PAUSE    = 6'h05;
  localparam logic [5:0] REG_SYNC     = 6'h06;
  localparam logic [5:0] REG_BPAT     = 6'h07;
  localparam logic [5:0] REG_PI       = 6'h08;
  localparam logic [5:0] REG_FIFO     = 6'h09;
  localparam logic [5:0] REG_LEVEL    = 6'h0a;
  localparam logic [5:0] REG_SEP_TAB  = 6'h10;
  localparam logic [5:0] REG_MUTE_TAB = 6'h18;
  localparam logic [5:0] REG_HCUT_TAB = 6'h20;

  // Interrupt bit positions
  localparam int IRQ_PAUSE = 0;
  localparam int IRQ_BMAT  = 1;
  localparam int IRQ_PI    = 2;
  localparam int IRQ_OVF   = 3;
  localparam int IRQ_SYNC  = 4;
  localparam int IRQ_W     = 5;

  // Reset values, and the floor for the acquire count
  localparam logic [7:0]  RST_S2M     = 8'h14;
  localparam logic [7:0]  RST_M2S     = 8'h1c;
  localparam logic [15:0] RST_PTHR    = 16'h0100;
  localparam logic [15:0] RST_PDUR    = 16'h0400;
  localparam logic [3:0]  RST_ACQ     = 4'h2;
  localparam logic [3:0]  RST_LOSS    = 4'h5;
  localparam logic [3:0]  MIN_ACQ     = 4'h2;
  localparam logic [3:0]  RST_PFILT   = 4'h8;

  // Block type codes carried in the buffer
  typedef enum logic [2:0] {
    FMRDS_BLK_A  = 3'b000,
    FMRDS_BLK_B  = 3'b001,
    FMRDS_BLK_C  = 3'b010,
    FMRDS_BLK_CP = 3'b011,
    FMRDS_BLK_D  = 3'b100,
    FMRDS_BLK_E  = 3'b101
  } fmrds_blk_t;

  typedef enum logic [1:0] {
    FMRDS_SEARCH = 2'b00,
    FMRDS_ACQ    = 2'b01,
    FMRDS_LOCK   = 2'b10
  } fmrds_sync_t;

endpackage : fmrds_pkg

// File: dv/fmrds_core_assertions.sv
// Port-level checker for the FM audio and data decoder core.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module fmrds_chk
  import fmrds_pkg::*;
#(
  parameter int AW = 16
) (
  input wire logic                 i_clock,
  input wire logic                 i_rst,
  input wire logic [5:0]           i_addr,
  input wire logic [31:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [31:0]          o_rdata,
  input wire logic                 i_aud_vld,
  input wire logic signed [AW-1:0] i_aud_l,
  input wire logic signed [AW-1:0] i_aud_r,
  input wire logic                 i_blk_vld,
  input wire logic signed [AW-1:0] o_aud_l,
  input wire logic signed [AW-1:0] o_aud_r,
  input wire logic                 o_aud_vld,
  input wire logic                 o_irq
);
  // ------------------------------------------------------------
  // Cycles since the last event or write, saturating at 7
  // ------------------------------------------------------------
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;
  logic       busy;
  assign busy    = i_wr | i_aud_vld | i_blk_vld;
  assign quiet_d = busy ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
  always_ff @(posedge i_clock) begin
    quiet_q <= i_rst ? 3'h7 : quiet_d;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_vld_follow: assert property (i_aud_vld |=> o_aud_vld)
    else $error("sample strobe not answered");
  a_vld_only: assert property (!i_aud_vld |=> !o_aud_vld)
    else $error("spurious sample strobe");
  a_aud_hold: assert property (!o_aud_vld |-> $stable(o_aud_l) && $stable(o_aud_r))
    else $error("audio changed between samples");
  a_aud_silent: assert property (i_aud_vld && i_aud_l == '0 && i_aud_r == '0
    |=> o_aud_l == '0 && o_aud_r == '0)
    else $error("silence not passed as silence");
  a_map_hole: assert property (i_rd && i_addr inside {[6'h0b:6'h0f], [6'h28:6'h3f]}
    |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask_off: assert property (i_wr && i_addr == REG_IRQ_MASK && i_wdata[4:0] == 5'h0
    |=> !o_irq)
    else $error("interrupt with all masked");
  a_irq_clear: assert property (i_wr && i_addr == REG_IRQ_STAT && i_wdata[4:0] == 5'h1f
    && quiet_q > 3'h2 && !i_aud_vld && !i_blk_vld |=> !o_irq)
    else $error("interrupt not cleared");
  a_irq_cause: assert property ($rose(o_irq) |-> quiet_q < 3'h4)
    else $error("interrupt without cause");
endmodule : fmrds_chk

bind fmrds_core fmrds_chk #(.AW(AW)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_aud_vld(i_aud_vld), .i_aud_l(i_aud_l),
  .i_aud_r(i_aud_r), .i_blk_vld(i_blk_vld), .o_aud_l(o_aud_l), .o_aud_r(o_aud_r),
  .o_aud_vld(o_aud_vld), .o_irq(o_irq));

// File: dv/fmrds_host.sv
// Host model: sets up and reads the core over its register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module fmrds_host (
  input  wire logic        i_clock,
  input  wire logic [31:0] i_rdata,
  output logic [5:0]       o_addr,
  output logic [31:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  // ------------------------------------------------------------
  // Bus starts low; once released, strobes idle low, address holds and data shows garbage
  // ------------------------------------------------------------
  initial begin
    o_addr  = 6'h0;
    o_wdata = 32'h0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // One-cycle write; configuration only goes this way
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_clock);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
    #1;
  endtask : wr

  // One-cycle read; data taken in the answer cycle only
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : rd
endmodule : fmrds_host

// File: dv/fmrds_audio_post_and_rds_decoder_tb.sv
// Self-checking bench for the FM audio post and data decoder core.
// Assumes the host model on the register port and a 10 MHz clock.
`timescale 1ns/1ps
module fm_audio_post_and_rds_decoder_tb;
  import fmrds_pkg::*;
  logic clk = 0, rst = 1, a_vld = 0, b_vld = 0, b_fix = 0, wr, rd, o_vld, irq;
  logic [7:0] cn = 8'h0, hcut;
  logic [5:0] addr;
  logic [1:0] b_errs = 2'h0;
  logic [15:0] b_data = 16'h0;
  logic signed [15:0] a_l = 16'sh0, a_r = 16'sh0, o_l, o_r;
  logic [31:0] wdata, rdata, tmp;
  fmrds_blk_t b_type = FMRDS_BLK_A;
  int error_cnt = 0, n_tests = 0;

  always #50 clk = ~clk;

  fmrds_core dut (.i_clock(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_cn(cn), .i_aud_vld(a_vld), .i_aud_l(a_l), .i_aud_r(a_r),
    .i_blk_vld(b_vld), .i_blk_data(b_data), .i_blk_type(b_type), .i_blk_errs(b_errs),
    .i_blk_fixable(b_fix), .o_aud_l(o_l), .o_aud_r(o_r), .o_aud_vld(o_vld), .o_hcut(hcut),
    .o_irq(irq));
  fmrds_host host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));

  // ------------------------------------------------------------
  // Shared drivers and compare
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    host.rd(a, tmp);
    chk(tmp & m, e);
  endtask : rdc
  task automatic setcn(input logic [7:0] v);
    @(posedge clk) cn <= v;
    repeat (3) @(posedge clk);
  endtask : setcn
  task automatic snd(input logic [15:0] l, input logic [15:0] r);
    @(posedge clk);
    a_vld <= 1'b1;
    a_l <= l;
    a_r <= r;
    @(posedge clk) a_vld <= 1'b0;
    #1;
  endtask : snd
  task automatic blk(input fmrds_blk_t t, input logic [15:0] d, input logic [1:0] e,
                     input logic f);
    @(posedge clk);
    b_vld <= 1'b1;
    b_type <= t;
    b_data <= d;
    b_errs <= e;
    b_fix <= f;
    @(posedge clk) b_vld <= 1'b0;
    #1;
  endtask : blk

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdc(REG_THR_SW, 32'hffff, 32'h1c14);
    rdc(REG_PAUSE, 32'hffffffff, 32'h0400_0100);
    rdc(REG_MUTE_TAB, 32'hff, 32'hff);
    rdc(REG_HCUT_TAB, 32'hff, 32'h0);
    rdc(6'h0c, 32'hffffffff, 32'h0);
    snd(16'h0, 16'h0);
    chk(o_l, 16'h0);
  endtask : t_reset

  // Hysteresis walk: the middle value keeps the previous choice
  task automatic t_switch;
    logic [7:0] cv[5] = '{8'h10, 8'h18, 8'h1c, 8'h18, 8'h10};
    logic st[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    host.wr(REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      setcn(cv[i]);
      snd(16'h1000, 16'h0);
      rdc(REG_STATUS, 32'h4, {29'h0, st[i], 2'h0});
      chk(o_r, st[i] ? 16'h0 : 16'h0800);
      chk(o_l, st[i] ? 16'h1000 : 16'h0800);
    end
  endtask : t_switch

  task automatic t_audio;
    host.wr(REG_CTRL, 32'h0);
    setcn(8'he0);
    host.wr(REG_SEP_TAB + 6'h7, 32'h0);
    snd(16'h1000, 16'h0);
    chk(o_r, 16'h0800);
    host.wr(REG_SEP_TAB + 6'h7, 32'hff);
    host.wr(REG_MUTE_TAB + 6'h7, 32'h40);
    host.wr(REG_HCUT_TAB + 6'h7, 32'h5a);
    snd(16'h1000, 16'h1000);
    chk(o_l, 16'h0400);
    chk(hcut, 8'h5a);
  endtask : t_audio

  // Silence of filter plus duration plus two samples, then a brief blip
  task automatic t_pause;
    host.wr(REG_PAUSE, 32'h0004_0100);
    host.wr(REG_IRQ_STAT, 32'h1f);
    host.wr(REG_IRQ_MASK, 32'h1);
    repeat (11) snd(16'h10, 16'h10);
    rdc(REG_IRQ_STAT, 32'h1, 32'h0);
    repeat (3) snd(16'h10, 16'h10);
    chk(irq, 1'b1);
    // A host would start its frequency jump here
    snd(16'h2000, 16'h2000);
    rdc(REG_STATUS, 32'h10, 32'h10);
    rdc(REG_IRQ_STAT, 32'h1, 32'h1);
    host.wr(REG_IRQ_STAT, 32'h1f);
    chk(irq, 1'b0);
    repeat (20) snd(16'h2000, 16'h2000);
    rdc(REG_STATUS, 32'h10, 32'h0);
  endtask : t_pause

  task automatic t_decode;
    host.wr(REG_SYNC, 32'h850);
    rdc(REG_SYNC, 32'hfff, 32'h852);
    host.wr(REG_BPAT, 32'hff00_4500);
    host.wr(REG_PI, 32'h1234);
    host.wr(REG_IRQ_MASK, 32'h0);
    host.wr(REG_IRQ_STAT, 32'h1f);
    blk(FMRDS_BLK_A, 16'h1234, 2'h0, 1'b0);
    blk(FMRDS_BLK_B, 16'h45aa, 2'h0, 1'b0);
    rdc(REG_STATUS, 32'hb, 32'ha);
    blk(FMRDS_BLK_C, 16'h0777, 2'h1, 1'b1);
    blk(FMRDS_BLK_D, 16'h0888, 2'h2, 1'b0);
    blk(FMRDS_BLK_A, 16'h1234, 2'h0, 1'b0);
    rdc(REG_IRQ_STAT, 32'h16, 32'h16);
    rdc(REG_LEVEL, 32'hff, 32'h3);
    rdc(REG_FIFO, 32'hffffffff, 32'h0009_45aa);
    rdc(REG_FIFO, 32'hffffffff, 32'h000a_0777);
    rdc(REG_FIFO, 32'hffffffff, 32'h0008_1234);
    rdc(REG_FIFO, 32'hffffffff, 32'h0);
  endtask : t_decode

  // Fill past the top, drain, then lose sync
  task automatic t_fill;
    for (int i = 0; i < 126; i++) blk(FMRDS_BLK_D, i[15:0], 2'h0, 1'b0);
    rdc(REG_STATUS, 32'hc0, 32'h40);
    blk(FMRDS_BLK_D, 16'hffff, 2'h0, 1'b0);
    rdc(REG_STATUS, 32'hc0, 32'hc0);
    rdc(REG_IRQ_STAT, 32'h8, 32'h8);
    rdc(REG_FIFO, 32'hffffffff, 32'h000c_0000);
    repeat (124) host.rd(REG_FIFO, tmp);
    rdc(REG_FIFO, 32'hffffffff, 32'h000c_007d);
    rdc(REG_STATUS, 32'ha0, 32'h20);
    repeat (5) blk(FMRDS_BLK_D, 16'h0, 2'h2, 1'b0);
    rdc(REG_STATUS, 32'h8, 32'h0);
  endtask : t_fill

  // Block E dropped while filtering; flush empties the buffer
  task automatic t_efilt;
    host.wr(REG_CTRL, 32'h2);
    blk(FMRDS_BLK_A, 16'h0001, 2'h0, 1'b0);
    blk(FMRDS_BLK_E, 16'h0002, 2'h0, 1'b0);
    blk(FMRDS_BLK_D, 16'h0003, 2'h0, 1'b0);
    rdc(REG_LEVEL, 32'hff, 32'h1);
    host.wr(REG_CTRL, 32'h4);
    rdc(REG_LEVEL, 32'hff, 32'h0);
  endtask : t_efilt

  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_switch();
    t_audio();
    t_pause();
    t_decode();
    t_fill();
    t_efilt();
    stop_test();
  end

  // Whole run is under a thousand cycles; this is fifty thousand
  initial begin
    #5_000_000;
    error_cnt++;
    stop_test();
  end
endmodule : fm_audio_post_and_rds_decoder_tb
